// ### core/sslo_map.svh
// Strap latch constants: defaults, fallback address, strap width and sync fill
// How it works
// - Capture all soft straps on reset release
// - EEPROM loader values replace latched straps
// - Pinless straps take fixed tie-off defaults
// - Straps drive settings or register reset defaults
// - Configured bits copy strap; affected bits combine
// - Soft reset or reload reverts without EEPROM
// - Soft reset and reload never resample pins
// - Indicator enable straps default all ones
// - Indicator function straps default all zeros
// - Override strap selects strap address, default clear
// - Slave address strap defaults to 0001010b
// - Timestamp pin sets timestamp enable reset value
// - Timestamp defaults give transparent clock operation
// - Auto crossover strap defaults one, sets status
// - Strap mode uses auto and manual straps
// - Manual strap: zero MDI, one MDIX
// - Crossover straps ignored in fibre mode; code still decodes xover_mode from them and only drops xover_active
// - Ready low until EEPROM configuration applied
// - Reload restarts loader, ready low meanwhile
`ifndef SSLO_MAP_SVH
`define SSLO_MAP_SVH
`define SSLO_IND_EN_DEFAULT 6'h3F
`define SSLO_IND_FUN_DEFAULT 3'h0
`define SSLO_ADDR_OVR_DEFAULT 1'h0
`define SSLO_SLAVE_ADDR_DEFAULT 7'h0A
`define SSLO_AUTO_XOVER_DEFAULT 1'h1
`define SSLO_MANUAL_XOVER_DEFAULT 1'h0
`define SSLO_FALLBACK_SLAVE_ADDR 7'h00
`define SSLO_XOVER_CTRL_STRAP 1'h0
`define SSLO_STRAP_WIDTH 20
`define SSLO_SYNC_FILL 2'h2
`endif

// ### core/sslo_pin_sync.sv
// Two-flop synchroniser for the strap pin bundle
`default_nettype none
module sslo_pin_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Raw and synchronised pin levels
	input wire logic [19:0] pins_async,
	output logic [19:0] pins_sync
);
	typedef struct packed {
		logic [19:0] first;
		logic [19:0] second;
	} sslo_sync_state_t;

	sslo_sync_state_t state;
	sslo_sync_state_t next_state;

	always_comb begin
		next_state.first = pins_async;
		next_state.second = state.first;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pins_sync = state.second;
endmodule
`default_nettype wire

// ### core/sslo_pkg.sv
// Types shared by the strap latch and its helpers
`default_nettype none
package sslo_pkg;
	typedef struct packed {
		logic [5:0] indicator_enable_straps;
		logic [2:0] indicator_function_straps;
		logic addr_override;
		logic [6:0] slave_address;
		logic timestamp_enable;
		logic auto_crossover;
		logic manual_crossover;
	} sslo_straps_t;

	typedef enum logic [1:0] {
		SSLO_XOVER_MDI,
		SSLO_XOVER_MDIX,
		SSLO_XOVER_AUTO
	} sslo_xover_t;

	typedef enum {
		SSLO_LOAD,
		SSLO_READY
	} sslo_phase_t;
endpackage
`default_nettype wire

// ### core/sslo_strap_latch.sv
// Soft strap latch with EEPROM override and ready tracking
`include "sslo_map.svh"
`default_nettype none
module sslo_strap_latch (
	// Clock and power-on or pin reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Strap pin
	input wire logic timestamp_enable_pin,
	// Soft resets
	input wire logic soft_reset,
	input wire logic eeprom_reload,
	// EEPROM loader
	input wire logic eeprom_present,
	input wire logic eeprom_done,
	input wire logic eeprom_valid,
	input wire sslo_pkg::sslo_straps_t eeprom_straps,
	output logic eeprom_start,
	// PHY A crossover
	input wire logic crossover_control_field,
	input wire logic crossover_control_value,
	input wire logic fibre_mode,
	output sslo_pkg::sslo_xover_t xover_mode,
	output logic xover_active,
	// Register defaults and settings
	output sslo_pkg::sslo_straps_t straps,
	output logic [5:0] indicator_enable_bits,
	output logic [2:0] indicator_function_field,
	output logic timestamp_enable_bit,
	output logic auto_crossover_strap_state_bit,
	output logic [6:0] slave_address,
	output logic ready
);
	import sslo_pkg::*;

	typedef struct packed {
		logic captured;
		logic [1:0] fill;
		sslo_straps_t latched;
		sslo_straps_t working;
		sslo_phase_t phase;
		logic start;
		logic ready;
	} sslo_state_t;

	sslo_state_t state;
	sslo_state_t next_state;
	logic [19:0] pins_sync;
	logic [19:0] pins_raw;

	// Only one strap has a pin; the rest are tie-offs
	function automatic sslo_straps_t strap_defaults(input logic ts_pin);
		sslo_straps_t s;
		s.indicator_enable_straps = `SSLO_IND_EN_DEFAULT;
		s.indicator_function_straps = `SSLO_IND_FUN_DEFAULT;
		s.addr_override = `SSLO_ADDR_OVR_DEFAULT;
		s.slave_address = `SSLO_SLAVE_ADDR_DEFAULT;
		s.timestamp_enable = ts_pin;
		s.auto_crossover = `SSLO_AUTO_XOVER_DEFAULT;
		s.manual_crossover = `SSLO_MANUAL_XOVER_DEFAULT;
		return s;
	endfunction

	assign pins_raw = {19'h00000, timestamp_enable_pin};

	sslo_pin_sync u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pins_async(pins_raw),
		.pins_sync(pins_sync)
	);

	always_comb begin
		next_state = state;
		next_state.start = 1'b0;
		// Wait for the synchroniser to fill before the one-shot capture
		if (!state.captured) begin
			// Sync flops come out of reset at zero, so sampling earlier
			// would latch a false low strap
			if (state.fill != `SSLO_SYNC_FILL) begin
				next_state.fill = state.fill + 2'h1;
			end else begin
				next_state.captured = 1'b1;
				next_state.latched = strap_defaults(pins_sync[0]);
				next_state.working = strap_defaults(pins_sync[0]);
				next_state.phase = SSLO_LOAD;
				next_state.start = 1'b1;
				next_state.ready = 1'b0;
			end
		end else if (soft_reset || eeprom_reload) begin
			// Reuse the latched copy; pins are never looked at here
			next_state.working = state.latched;
			next_state.phase = SSLO_LOAD;
			next_state.start = 1'b1;
			next_state.ready = 1'b0;
		end else begin
			case (state.phase)
				SSLO_LOAD: begin
					if (!eeprom_present) begin
						next_state.phase = SSLO_READY;
						next_state.ready = 1'b1;
					end else if (eeprom_done) begin
						if (eeprom_valid) begin
							next_state.working = eeprom_straps;
						end else begin
							next_state.working = state.latched;
						end
						next_state.phase = SSLO_READY;
						next_state.ready = 1'b1;
					end
				end
				SSLO_READY: begin
					next_state.ready = 1'b1;
				end
				default: begin
					next_state.phase = SSLO_LOAD;
				end
			endcase
		end
	end

	// Re-latching needs rst_n itself; no soft path clears captured
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	sslo_xover_decode u_xover (
		.auto_crossover(state.working.auto_crossover),
		.manual_crossover(state.working.manual_crossover),
		.crossover_control_field(crossover_control_field),
		.crossover_control_value(crossover_control_value),
		.fibre_mode(fibre_mode),
		.xover_mode(xover_mode),
		.xover_active(xover_active)
	);

	assign eeprom_start = state.start;
	assign ready = state.ready;
	assign straps = state.working;
	assign indicator_enable_bits =
		state.working.indicator_enable_straps;
	assign indicator_function_field =
		state.working.indicator_function_straps;
	// Default 1588 set left untouched yields transparent clock
	assign timestamp_enable_bit = state.working.timestamp_enable;
	assign auto_crossover_strap_state_bit =
		state.working.auto_crossover;
	assign slave_address = state.working.addr_override ?
		state.working.slave_address : `SSLO_FALLBACK_SLAVE_ADDR;
endmodule
`default_nettype wire

// ### core/sslo_xover_decode.sv
// Crossover mode decode for PHY A
`default_nettype none
module sslo_xover_decode
	import sslo_pkg::*;
(
	// Controls
	input wire logic auto_crossover,
	input wire logic manual_crossover,
	input wire logic crossover_control_field,
	input wire logic crossover_control_value,
	input wire logic fibre_mode,
	// Result
	output sslo_pkg::sslo_xover_t xover_mode,
	output logic xover_active
);
	always_comb begin
		xover_active = !fibre_mode;
		if (!crossover_control_field) begin
			xover_mode = crossover_control_value ? SSLO_XOVER_AUTO
				: SSLO_XOVER_MDI;
		end else if (auto_crossover) begin
			xover_mode = SSLO_XOVER_AUTO;
		end else if (manual_crossover) begin
			xover_mode = SSLO_XOVER_MDIX;
		end else begin
			xover_mode = SSLO_XOVER_MDI;
		end
	end
endmodule
`default_nettype wire

// ### test/sslo_eeprom_model.sv
// Behavioural EEPROM loader that answers start requests
`default_nettype none
module sslo_eeprom_model
	import sslo_pkg::*;
(
	// Clock, reset and handshake
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic eeprom_start,
	input wire logic eeprom_present,
	output logic eeprom_done,
	output logic eeprom_valid,
	output sslo_pkg::sslo_straps_t eeprom_straps,
	// Image control from the bench
	input wire logic blank,
	input wire logic [3:0] lat,
	input wire sslo_pkg::sslo_straps_t image
);
	logic [3:0] cnt;
	// Off-cycle data is inverted so a stale sample cannot pass
	assign eeprom_straps = eeprom_done ? image : ~image;
	assign eeprom_valid = !blank;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			eeprom_done <= 1'h0;
		end else begin
			eeprom_done <= (cnt == 4'h1);
			if (eeprom_start && eeprom_present) // Each start restarts
				cnt <= lat;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### test/sslo_strap_latch_checker.sv
// Port-level assertions for the soft strap latch
`default_nettype none
module sslo_strap_latch_checker
	import sslo_pkg::*;
(
	// Clock, reset and requests
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic eeprom_reload,
	// Loader and outputs
	input wire logic eeprom_present,
	input wire logic eeprom_done,
	input wire logic eeprom_valid,
	input wire sslo_pkg::sslo_straps_t eeprom_straps,
	input wire logic eeprom_start,
	input wire logic crossover_control_field,
	input wire logic fibre_mode,
	input wire sslo_pkg::sslo_xover_t xover_mode,
	input wire sslo_pkg::sslo_straps_t straps,
	input wire logic [6:0] slave_address,
	input wire logic ready
);
	logic req_seen;
	assign req_seen = soft_reset || eeprom_reload;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		req_seen;
	endsequence
	sequence s_load;
		!ready && !eeprom_start && eeprom_done && eeprom_present
			&& !req_seen;
	endsequence
	AST_REQ_RESTART: assert property (s_req |=> eeprom_start && !ready)
		else $error("no restart");
	AST_START_ONE: assert property (eeprom_start && !req_seen
		|=> !eeprom_start) else $error("start too long");
	AST_NO_EEPROM: assert property (eeprom_start && !eeprom_present
		&& !req_seen |=> ready) else $error("no ready without loader");
	AST_DONE_READY: assert property (s_load |=> ready)
		else $error("no ready after done");
	AST_OVERRIDE: assert property (s_load and eeprom_valid
		|=> straps == $past(eeprom_straps)) else $error("no override");
	AST_HOLD: assert property (ready && !req_seen
		|=> ready && $stable(straps)) else $error("straps moved");
	AST_ADDR: assert property (slave_address == (straps.addr_override
		? straps.slave_address : 7'h00)) else $error("bad address");
	AST_XOVER: assert property (crossover_control_field && !fibre_mode
		|-> xover_mode == (straps.auto_crossover ? SSLO_XOVER_AUTO
		: straps.manual_crossover ? SSLO_XOVER_MDIX : SSLO_XOVER_MDI))
		else $error("bad crossover");
endmodule
bind sslo_strap_latch sslo_strap_latch_checker i_chk (.*);
`default_nettype wire

// ### test/sslo_strap_latch_tb.sv
// Self-checking bench for the soft strap latch
`default_nettype none
module sslo_strap_latch_tb;
	import sslo_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam sslo_straps_t dflt =
		'{6'h3F, 3'h0, 1'h0, 7'h0A, 1'h0, 1'h1, 1'h0};
	localparam sslo_straps_t img =
		'{6'h15, 3'h5, 1'h1, 7'h33, 1'h1, 1'h0, 1'h1};
	logic ref_clk = 0, rst_n = 0, timestamp_enable_pin = 1, soft_reset = 0;
	sslo_straps_t held;
	logic eeprom_reload = 0, eeprom_present = 0, blank = 0, fibre_mode = 0;
	logic crossover_control_field = 1, crossover_control_value = 0;
	logic [3:0] lat = 4'h3;
	sslo_straps_t image = img;
	sslo_straps_t eeprom_straps, straps;
	sslo_xover_t xover_mode;
	logic eeprom_done, eeprom_valid, eeprom_start, xover_active, ready;
	logic timestamp_enable_bit, auto_crossover_strap_state_bit;
	logic [5:0] indicator_enable_bits;
	logic [2:0] indicator_function_field;
	logic [6:0] slave_address;
	int err_total = 0, check_count = 0;
	sslo_strap_latch i_sslo_strap_latch (.*);
	sslo_eeprom_model i_sslo_eeprom_model (.*);
	always #4 ref_clk = ~ref_clk;
	task summarize;
		if (err_total == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait: a hung loader must not stall the run
	task wait_ready;
		for (int n = 0; n < 60 && ready !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (ready !== 1'b1) begin
			chk(20'h0, 20'h1);
			summarize();
		end
	endtask
	// One pulse of soft reset (reload = 0) or reload command (reload = 1)
	task req(input logic reload);
		@(posedge ref_clk);
		if (reload) begin
			eeprom_reload <= 1'b1;
		end else begin
			soft_reset <= 1'b1;
		end
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		eeprom_reload <= 1'b0;
		#1;
		wait_ready();
	endtask
	// Pin level ts must be latched; held keeps the expected latched copy
	task do_reset(input logic ts);
		held = dflt;
		held.timestamp_enable = ts;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		wait_ready();
		chk(straps, held);
		chk(20'(timestamp_enable_bit), 20'(ts));
	endtask
	initial begin
		do_reset(1'b1);
		chk(20'(xover_mode), 20'(SSLO_XOVER_AUTO));
		chk(20'(xover_active), 20'h1);
		chk(20'(slave_address), 20'h0);
		eeprom_present <= 1'b1;
		timestamp_enable_pin <= 1'b0;
		req(1'b0);
		chk(straps, img);
		chk(20'(slave_address), 20'h33);
		chk(20'(indicator_enable_bits), 20'h15);
		chk(20'(indicator_function_field), 20'h5);
		chk(20'(auto_crossover_strap_state_bit), 20'h0);
		chk(20'(timestamp_enable_bit), 20'h1);
		chk(20'(xover_mode), 20'(SSLO_XOVER_MDIX));
		blank <= 1'b1;
		lat <= 4'hC;
		req(1'b1);
		chk(straps, held);
		blank <= 1'b0;
		req(1'b1);
		chk(straps, img);
		eeprom_present <= 1'b0;
		req(1'b1);
		chk(straps, held);
		crossover_control_field <= 1'b0;
		crossover_control_value <= 1'b1;
		#8;
		chk(20'(xover_mode), 20'(SSLO_XOVER_AUTO));
		crossover_control_value <= 1'b0;
		#8;
		chk(20'(xover_mode), 20'(SSLO_XOVER_MDI));
		fibre_mode <= 1'b1;
		#8;
		chk(20'(xover_active), 20'h0);
		rst_n <= 1'b0;
		do_reset(1'b0);
		summarize();
	end
endmodule
`default_nettype wire
